// ### tb/qbp_pins_ext.sv
// Outside circuitry on the port pins: pull-ups and optional external drivers
`timescale 1ns/1ns
module qbp_pins_ext (
  input  wire logic [31:0] pin_o,
  input  wire logic [31:0] pin_oe_n_o,
  input  wire logic [31:0] ext_en_i,
  input  wire logic [31:0] ext_v_i,
  output logic      [31:0] lvl_o
);
  ////////////////////////////////////////
  // Strong drive wins; otherwise an outside driver beats the weak pull-up
  assign lvl_o = (~pin_oe_n_o & pin_o) | (pin_oe_n_o & ext_en_i & ext_v_i) | (pin_oe_n_o & ~ext_en_i);
endmodule

// ### tb/qbp_ports_asserts.sv
// Concurrent checks on the port block pins and register bus
`timescale 1ns/1ns
module qbp_ports_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic [31:0] pin_i,
  input wire logic [31:0] pin_o,
  input wire logic [31:0] pin_oe_n_o,
  input wire logic        uart0_rx_o,
  input wire logic        can_rx_in_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Filter checks wait until the synchroniser has refilled after reset
  logic [2:0] up_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  ////////////////////////////////////////
  a_ack_one_wait:
    assert property (cyc_i && stb_i && ce_i && !ack_o |=> ack_o) else $error("ack late");
  a_ack_pulse:
    assert property (ack_o && ce_i |=> !ack_o) else $error("ack held");
  a_ack_cause:
    assert property ($rose(ack_o) |-> $past(cyc_i && stb_i)) else $error("ack unasked");
  a_rst_weak_high:
    assert property ($fell(rst_i) |-> pin_oe_n_o == 32'hffffffff && pin_o == 32'hffffffff && !ack_o)
    else $error("reset drive");
  for (genvar i = 0; i < 32; i++) begin : g_bit
    a_low_strong:
      assert property (!pin_o[i] |-> !pin_oe_n_o[i]) else $error("weak low");
    a_rise_pulse:
      assert property ($rose(pin_o[i]) |-> !pin_oe_n_o[i] [*2] ##1 (pin_oe_n_o[i] || !pin_o[i]))
      else $error("pulse length");
  end
  a_rx0_follow:
    assert property ((up_q == 3'h7 && $stable(pin_i[0])) [*6] |-> uart0_rx_o == pin_i[0])
    else $error("rx0 level");
  a_canrx_follow:
    assert property ((up_q == 3'h7 && $stable(pin_i[17])) [*6] |-> can_rx_in_o == pin_i[17])
    else $error("can rx level");
  c_bus: cover property (ack_o);
  c_pulse: cover property ($rose(pin_o[8]));
  c_ext_low: cover property (!pin_i[0] && pin_oe_n_o[0]);
endmodule
bind qbp_ports qbp_ports_asserts qbp_ports_asserts_inst (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .ack_o,
  .pin_i, .pin_o, .pin_oe_n_o, .uart0_rx_o, .can_rx_in_o);

// ### tb/qbp_ports_tb.sv
// Self-checking bench of the quasi-bidirectional port block
`timescale 1ns/1ns
`include "qbp_defines.svh"
module qbp_ports_tb;
  logic        clk_i;
  logic        rst_i;
  logic        cyc, we, ack, utx, t1c, wrs, rds, ctx, u2tx, coe;
  logic [7:0]  adr, ce8;
  logic [31:0] dat, rdat, po, oe_n, lvl, ext_en, ev, r;
  logic [5:0]  ahi;
  logic [3:0]  pce;
  wire  [7:0]  core;
  logic [31:0] exp_q[$];
  int          failures, n_compared, seed;

  qbp_ports qbp_ports_inst (.clk_i, .rst_i, .ce_i(1'b1), .cyc_i(cyc), .stb_i(cyc), .we_i(we), .adr_i(adr),
    .sel_i(4'h1), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .pin_i(lvl), .pin_o(po), .pin_oe_n_o(oe_n),
    .uart0_tx_i(utx), .timer1_clk_out_i(t1c), .clk_out_en_i(coe), .ext_wr_strobe_i(wrs),
    .ext_rd_strobe_i(rds), .prog_mem_chip_en_i(ce8), .mem_addr_hi_i(ahi), .can_tx_out_i(ctx),
    .periph_chip_en_i(pce), .uart2_tx_i(u2tx), .uart0_rx_o(core[0]), .ext_irq0_in_o(core[1]),
    .ext_irq1_in_o(core[2]), .timer0_ext_in_o(core[3]), .timer1_ext_in_o(core[4]),
    .can_rx_in_o(core[5]), .timer3_ext_in_o(core[6]), .uart2_rx_o(core[7]));
  qbp_pins_ext qbp_pins_ext_inst (.pin_o(po), .pin_oe_n_o(oe_n), .ext_en_i(ext_en), .ext_v_i(ev), .lvl_o(lvl));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      failures++;
      $display("BAD at %0t got %h want %h", $time, got, want);
    end
  endtask
  // Called just after a rising edge; holds the request until ack is seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    wb(1'b0, a, 32'h0);
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_i)
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) chk(rdat, exp_q.pop_front());
  ////////////////////////////////////////
  initial begin
    seed = 16240;
    {cyc, we, adr, dat, ext_en, ev} = '0;
    {utx, t1c, wrs, rds, ctx, u2tx, coe, ce8, ahi, pce} = '1;
    rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`QBP_ADR_LATCH_P3, 8'hff);
    rd(`QBP_ADR_PIN_P6, 8'hff);
    rd(8'h40, 8'h00);
    $display("done reset");
    r = $random(seed) & 32'hfe;
    wb(1'b1, `QBP_ADR_LATCH_P4, r);
    repeat (8) @(posedge clk_i);
    chk({24'h0, oe_n[15:8]}, r);
    rd(`QBP_ADR_PIN_P4, r[7:0]);
    wb(1'b1, `QBP_ADR_LATCH_P4, 32'hff);
    repeat (8) @(posedge clk_i);
    rd(`QBP_ADR_PIN_P4, 8'hff);
    $display("done drive");
    ext_en <= '1;
    ev <= $random(seed);
    repeat (8) @(posedge clk_i);
    for (int i = 0; i < 4; i++) rd(`QBP_ADR_PIN_P3 + 8'(4 * i), ev[8*i +: 8]);
    $display("done input");
    r = $random(seed);
    {utx, t1c, wrs, rds, ctx, u2tx, pce} <= r[9:0];
    ce8 <= r[17:10];
    ahi <= r[23:18];
    ext_en <= 32'h4006_001d;
    ev <= $random(seed);
    wb(1'b1, `QBP_ADR_P4CFG, 32'hff);
    wb(1'b1, `QBP_ADR_ALT_P3, 32'hff);
    wb(1'b1, `QBP_ADR_ALT_P5, 32'hff);
    wb(1'b1, `QBP_ADR_ALT_P6, 32'hff);
    repeat (8) @(posedge clk_i);
    rd(`QBP_ADR_PIN_P3, {rds, wrs, t1c, ev[4:2], utx, ev[0]});
    rd(`QBP_ADR_PIN_P4, {ahi[3:0], ce8[3:0]});
    rd(`QBP_ADR_PIN_P5, {pce, 1'b1, ev[18:17], ctx});
    rd(`QBP_ADR_PIN_P6, {u2tx, ev[30], ahi[5:4], ce8[7:4]});
    chk({24'h0, core}, {24'h0, ev[30], ev[18:17], t1c, ev[4:2], ev[0]});
    $display("done alternates");
    // Without the clock output enable the timer 1 pin falls back to a weak-high input
    coe <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd(`QBP_ADR_PIN_P3, {rds, wrs, 1'b1, ev[4:2], utx, ev[0]});
    chk({31'h0, core[4]}, 32'h1);
    $display("done clock out");
    // Reset in mid-run must restore latches and weak-high drive
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(oe_n, 32'hffff_ffff);
    chk(po, 32'hffff_ffff);
    rd(`QBP_ADR_LATCH_P4, 8'hff);
    rd(`QBP_ADR_P4CFG, 8'h00);
    $display("done mid reset");
    give_verdict();
  end
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    #(2000 * 100);
    failures++;
    give_verdict();
  end
endmodule

// ### verilog/qbp_defines.svh
// Register offsets, reset values and timing counts of the quasi-bidirectional port block
`ifndef QBP_DEFINES_SVH
`define QBP_DEFINES_SVH

// Wishbone byte addresses, one aligned 32-bit word per register
`define QBP_ADR_LATCH_P3   8'h00
`define QBP_ADR_LATCH_P4   8'h04
`define QBP_ADR_LATCH_P5   8'h08
`define QBP_ADR_LATCH_P6   8'h0c
`define QBP_ADR_PIN_P3     8'h10
`define QBP_ADR_PIN_P4     8'h14
`define QBP_ADR_PIN_P5     8'h18
`define QBP_ADR_PIN_P6     8'h1c
`define QBP_ADR_P4CFG      8'h20
`define QBP_ADR_ALT_P3     8'h24
`define QBP_ADR_ALT_P5     8'h28
`define QBP_ADR_ALT_P6     8'h2c

// Reset values
`define QBP_RST_LATCH      8'hff
`define QBP_RST_P4CFG      8'h00
`define QBP_RST_ALT        8'h00
`define QBP_RST_PINS       32'hffff_ffff

// Bits that own an alternate output function, per port
`define QBP_ALT_OUT_P3     8'he2
`define QBP_ALT_OUT_P5     8'hf1
`define QBP_ALT_OUT_P6     8'hbf

// Port lanes in the flattened 32-bit pin vectors
`define QBP_LANE_P3        0
`define QBP_LANE_P4        8
`define QBP_LANE_P5        16
`define QBP_LANE_P6        24

// Strong transition driver on time, least time, rounded up
`define QBP_CLK_PERIOD_NS  100
`define QBP_STRONG_HI_NS   200
`define QBP_STRONG_HI_CYC  (((`QBP_STRONG_HI_NS) + (`QBP_CLK_PERIOD_NS) - 1) / (`QBP_CLK_PERIOD_NS))

`endif

// ### verilog/qbp_pkg.sv
// Types shared by the quasi-bidirectional port block
package qbp_pkg;

  typedef enum logic [2:0] {
    QBP_SEL_LATCH,
    QBP_SEL_PIN,
    QBP_SEL_P4CFG,
    QBP_SEL_ALT,
    QBP_SEL_NONE
  } qbp_reg_sel_t;

  typedef logic [7:0] qbp_byte_t;
  typedef logic [1:0] qbp_port_idx_t;

endpackage

// ### verilog/qbp_ports.sv
// Quasi-bidirectional ports 3 to 6 with alternate function muxing and a Wishbone register slave
//
// Overview of operation
// - Reset sets every port latch bit to one
// - Latched one is weak high, usable as input
// - Written zero holds strong pull-down until one/reset
// - Zero-to-one gives brief strong high, then weak
// - Port4 config register selects I/O or memory
// - Port4 bits 0-3 drive program chip enables 0-3
// - Port4 bits 4-7 drive address bits 16-19
// - Port5 bit0 CAN transmit, bit1 CAN receive
// - Port5 bit2 timer3 input; bit3 plain I/O
// - Port5 bits 4-7 drive peripheral chip enables
// - Port6 bits 0-3 drive program chip enables 4-7
// - Port6 bits 4-5 drive address bits 20-21
// - Port6 bit6 uart2 receive, bit7 uart2 transmit
// - Port3 bit4 timer0 input; bit5 timer1/clock out
// - Port3 bits 6/7 drive data write/read strobes
// - Port3 bit0 uart0 receive, bit1 uart0 transmit
// - Port3 bits 2/3 external interrupt 0/1 inputs
//
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "qbp_defines.svh"

module qbp_ports
  import qbp_pkg::*;
#(
  parameter bit CAN_PRESENT = 1'b1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Pins: [7:0] port 3, [15:8] port 4, [23:16] port 5, [31:24] port 6
  input  wire logic [31:0] pin_i,
  output logic      [31:0] pin_o,
  output logic      [31:0] pin_oe_n_o,
  // Alternate outputs from the core peripherals
  input  wire logic        uart0_tx_i,
  input  wire logic        timer1_clk_out_i,
  input  wire logic        clk_out_en_i,
  input  wire logic        ext_wr_strobe_i,
  input  wire logic        ext_rd_strobe_i,
  input  wire logic [7:0]  prog_mem_chip_en_i,
  input  wire logic [5:0]  mem_addr_hi_i,
  input  wire logic        can_tx_out_i,
  input  wire logic [3:0]  periph_chip_en_i,
  input  wire logic        uart2_tx_i,
  // Alternate inputs to the core peripherals
  output logic             uart0_rx_o,
  output logic             ext_irq0_in_o,
  output logic             ext_irq1_in_o,
  output logic             timer0_ext_in_o,
  output logic             timer1_ext_in_o,
  output logic             can_rx_in_o,
  output logic             timer3_ext_in_o,
  output logic             uart2_rx_o
);

  localparam int unsigned STRONG_CYC = (`QBP_STRONG_HI_CYC < 1) ? 1 : `QBP_STRONG_HI_CYC;
  localparam logic [2:0]  STRONG_CNT = 3'(STRONG_CYC - 1);
  localparam qbp_byte_t   CAN_MASK   = CAN_PRESENT ? 8'hff : 8'hfe;

  //////////////////////////////////////////////////////////////////////////////
  // Software visible state

  qbp_byte_t    latch_q [4];
  qbp_byte_t    p4cfg_q;
  qbp_byte_t    alt3_q;
  qbp_byte_t    alt5_q;
  qbp_byte_t    alt6_q;
  logic [31:0]  sync1_q;
  logic [31:0]  sync2_q;
  logic [31:0]  sync3_q;
  logic [31:0]  pins_q;
  logic         ack_q;
  logic [31:0]  dat_q;

  qbp_reg_sel_t   reg_sel;
  qbp_port_idx_t  reg_port;
  logic           bus_req;
  logic           wr_lane0;

  assign bus_req  = cyc_i & stb_i & ~ack_q;
  assign wr_lane0 = bus_req & we_i & sel_i[0];

  always_comb begin
    reg_sel  = QBP_SEL_NONE;
    reg_port = 2'h0;
    case (adr_i)
      `QBP_ADR_LATCH_P3: begin reg_sel = QBP_SEL_LATCH; reg_port = 2'h0; end
      `QBP_ADR_LATCH_P4: begin reg_sel = QBP_SEL_LATCH; reg_port = 2'h1; end
      `QBP_ADR_LATCH_P5: begin reg_sel = QBP_SEL_LATCH; reg_port = 2'h2; end
      `QBP_ADR_LATCH_P6: begin reg_sel = QBP_SEL_LATCH; reg_port = 2'h3; end
      `QBP_ADR_PIN_P3:   begin reg_sel = QBP_SEL_PIN;   reg_port = 2'h0; end
      `QBP_ADR_PIN_P4:   begin reg_sel = QBP_SEL_PIN;   reg_port = 2'h1; end
      `QBP_ADR_PIN_P5:   begin reg_sel = QBP_SEL_PIN;   reg_port = 2'h2; end
      `QBP_ADR_PIN_P6:   begin reg_sel = QBP_SEL_PIN;   reg_port = 2'h3; end
      `QBP_ADR_P4CFG:    begin reg_sel = QBP_SEL_P4CFG; reg_port = 2'h1; end
      `QBP_ADR_ALT_P3:   begin reg_sel = QBP_SEL_ALT;   reg_port = 2'h0; end
      `QBP_ADR_ALT_P5:   begin reg_sel = QBP_SEL_ALT;   reg_port = 2'h2; end
      `QBP_ADR_ALT_P6:   begin reg_sel = QBP_SEL_ALT;   reg_port = 2'h3; end
      default:           begin reg_sel = QBP_SEL_NONE;  reg_port = 2'h0; end
    endcase
  end

  // Port latches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int p = 0; p < 4; p++) begin
        latch_q[p] <= `QBP_RST_LATCH;
      end
    end else if (ce_i && wr_lane0 && reg_sel == QBP_SEL_LATCH) begin
      latch_q[reg_port] <= dat_i[7:0];
    end
  end

  // Alternate function selects; unmapped bits stay zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p4cfg_q <= `QBP_RST_P4CFG;
      alt3_q  <= `QBP_RST_ALT;
      alt5_q  <= `QBP_RST_ALT;
      alt6_q  <= `QBP_RST_ALT;
    end else if (ce_i && wr_lane0) begin
      if (reg_sel == QBP_SEL_P4CFG) begin
        p4cfg_q <= dat_i[7:0];
      end
      if (reg_sel == QBP_SEL_ALT && reg_port == 2'h0) begin
        alt3_q <= dat_i[7:0] & `QBP_ALT_OUT_P3;
      end
      if (reg_sel == QBP_SEL_ALT && reg_port == 2'h2) begin
        alt5_q <= dat_i[7:0] & `QBP_ALT_OUT_P5 & CAN_MASK;
      end
      if (reg_sel == QBP_SEL_ALT && reg_port == 2'h3) begin
        alt6_q <= dat_i[7:0] & `QBP_ALT_OUT_P6;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Wishbone answer: one wait state, ack for every address, unmapped reads zero

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_q <= bus_req;
      if (bus_req && !we_i) begin
        case (reg_sel)
          QBP_SEL_LATCH: dat_q <= {24'h00_0000, latch_q[reg_port]};
          QBP_SEL_PIN:   dat_q <= {24'h00_0000, pins_q[8*reg_port +: 8]};
          QBP_SEL_P4CFG: dat_q <= {24'h00_0000, p4cfg_q};
          QBP_SEL_ALT: begin
            case (reg_port)
              2'h0:    dat_q <= {24'h00_0000, alt3_q};
              2'h2:    dat_q <= {24'h00_0000, alt5_q};
              2'h3:    dat_q <= {24'h00_0000, alt6_q};
              default: dat_q <= 32'h0000_0000;
            endcase
          end
          default:       dat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

  //////////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser: three stages, a change counts once stages two and three agree

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= `QBP_RST_PINS;
      sync2_q <= `QBP_RST_PINS;
      sync3_q <= `QBP_RST_PINS;
      pins_q  <= `QBP_RST_PINS;
    end else if (ce_i) begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pins_q  <= (sync2_q & ~(sync2_q ^ sync3_q)) | (pins_q & (sync2_q ^ sync3_q));
    end
  end

  // Inputs to peripherals come straight from the filtered pin flops
  assign uart0_rx_o      = pins_q[`QBP_LANE_P3 + 0];
  assign ext_irq0_in_o   = pins_q[`QBP_LANE_P3 + 2];
  assign ext_irq1_in_o   = pins_q[`QBP_LANE_P3 + 3];
  assign timer0_ext_in_o = pins_q[`QBP_LANE_P3 + 4];
  assign timer1_ext_in_o = pins_q[`QBP_LANE_P3 + 5];
  assign can_rx_in_o     = pins_q[`QBP_LANE_P5 + 1];
  assign timer3_ext_in_o = pins_q[`QBP_LANE_P5 + 2];
  assign uart2_rx_o      = pins_q[`QBP_LANE_P6 + 6];

  //////////////////////////////////////////////////////////////////////////////
  // Alternate output multiplexing

  logic [31:0] alt_val;
  logic [31:0] alt_en;
  logic [31:0] drive_val;
  logic [31:0] latch_flat;

  always_comb begin
    alt_val = 32'hffff_ffff;
    alt_val[`QBP_LANE_P3 + 1] = uart0_tx_i;
    alt_val[`QBP_LANE_P3 + 5] = timer1_clk_out_i;
    alt_val[`QBP_LANE_P3 + 6] = ext_wr_strobe_i;
    alt_val[`QBP_LANE_P3 + 7] = ext_rd_strobe_i;
    alt_val[`QBP_LANE_P4 +: 4] = prog_mem_chip_en_i[3:0];
    alt_val[`QBP_LANE_P4 + 4 +: 4] = mem_addr_hi_i[3:0];
    alt_val[`QBP_LANE_P5 + 0] = can_tx_out_i;
    alt_val[`QBP_LANE_P5 + 4 +: 4] = periph_chip_en_i;
    alt_val[`QBP_LANE_P6 +: 4] = prog_mem_chip_en_i[7:4];
    alt_val[`QBP_LANE_P6 + 4 +: 2] = mem_addr_hi_i[5:4];
    alt_val[`QBP_LANE_P6 + 7] = uart2_tx_i;
  end

  // Timer 1 pin only turns into a clock output while the clock output is enabled;
  // otherwise it stays a plain input so the timer can count on it.
  always_comb begin
    alt_en = {alt6_q, alt5_q, p4cfg_q, alt3_q};
    alt_en[`QBP_LANE_P3 + 5] = alt3_q[5] & clk_out_en_i;
    alt_en[`QBP_LANE_P5 + 3] = 1'b0;
  end

  assign latch_flat = {latch_q[3], latch_q[2], latch_q[1], latch_q[0]};
  assign drive_val  = (alt_en & alt_val) | (~alt_en & latch_flat);

  //////////////////////////////////////////////////////////////////////////////
  // Pin drivers: strong low, momentary strong high, then weak pull-up (driver off)

  for (genvar b = 0; b < 32; b++) begin : g_pin
    logic       prev_q;
    logic [2:0] cnt_q;

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        prev_q        <= 1'b1;
        cnt_q         <= 3'h0;
        pin_o[b]      <= 1'b1;
        pin_oe_n_o[b] <= 1'b1;
      end else if (ce_i) begin
        prev_q <= drive_val[b];
        if (!drive_val[b]) begin
          cnt_q         <= 3'h0;
          pin_o[b]      <= 1'b0;
          pin_oe_n_o[b] <= 1'b0;
        end else if (!prev_q) begin
          cnt_q         <= STRONG_CNT;
          pin_o[b]      <= 1'b1;
          pin_oe_n_o[b] <= 1'b0;
        end else if (cnt_q != 3'h0) begin
          cnt_q         <= cnt_q - 3'h1;
          pin_o[b]      <= 1'b1;
          pin_oe_n_o[b] <= 1'b0;
        end else begin
          pin_o[b]      <= 1'b1;
          pin_oe_n_o[b] <= 1'b1;
        end
      end
    end
  end

endmodule
